// ===== hdl/chip_select_code_decoder.sv
`timescale 1ns/1ns
`default_nettype none

module chip_select_code_decoder
(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic [csd_pkg::CODE_W-1:0]  select_code_lines,
  input  wire logic                        decode_enable_n,
  input  wire logic                        dma_ack_gate,
  input  wire logic                        iow_n,
  input  wire logic                        ior_n,
  input  wire logic                        addr_a0,
  input  wire logic                        bale,
  input  wire logic                        bale_in_use,
  output logic                             bios_rom_output_enable,
  output logic                             kbd_ctrl_select,
  output logic                             math_coproc_select,
  output logic                             power_unit0_write_strobe,
  output logic                             power_unit1_write_strobe,
  output logic                             kbd_proc_ack,
  output logic                             rtc_addr_latch_enable,
  output logic                             rtc_write_strobe,
  output logic                             rtc_read_strobe,
  output logic                             floppy_output_reg_select,
  output logic                             floppy_chip_select,
  output logic                             floppy_control_reg_select,
  output logic                             ide_low_buffer_enable,
  output logic                             ide_high_buffer_enable,
  output logic                             ide_card_select_zero,
  output logic                             ide_card_select_one,
  output logic                             serial_a_select,
  output logic                             serial_b_select,
  output logic                             parallel_port_select,
  output logic                             programmable_select,
  output logic                             expanded_mem_select,
  output logic                             fast_clock_enable,
  output logic                             suspend_active,
  output logic                             companion_clock_out,
  output logic                             suspend_refresh_pulse,
  output logic [csd_pkg::DATA_W-1:0]       host_data_bus_out,
  output logic                             host_data_bus_oe
);
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_N-1:0]   pins;
  logic [PIN_N-1:0]   meta_q;
  logic [PIN_N-1:0]   sync_q;

  assign pins = {bale, addr_a0, ior_n, iow_n, dma_ack_gate, decode_enable_n, select_code_lines};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  logic [CODE_W-1:0]  code_live;
  logic               enabled;
  logic               iow_low;
  logic               ior_low;

  assign code_live = sync_q[PIN_CODE +: CODE_W];
  assign enabled   = !sync_q[PIN_EN_N] && !sync_q[PIN_DACK];
  assign iow_low   = !sync_q[PIN_IOW_N];
  assign ior_low   = !sync_q[PIN_IOR_N];

  // ----------------------------------------------------------------
  // address-latch capture of the code lines
  // ----------------------------------------------------------------
  logic [CODE_W-1:0]  code_lat_q;
  logic [CODE_W-1:0]  code_eff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      code_lat_q <= {CODE_W{1'b0}};
    else if (sync_q[PIN_ALE])
      code_lat_q <= code_live;
  end

  // transparent while the strobe is high, held after it falls
  assign code_eff = (bale_in_use && !sync_q[PIN_ALE]) ? code_lat_q : code_live;

  // ----------------------------------------------------------------
  // companion clock
  // ----------------------------------------------------------------
  mode_t              mode_q;
  logic               cclk_q;
  logic [NCO_W-1:0]   nco_q;
  logic [NCO_W:0]     nco_sum;
  logic               cclk_toggle;
  logic               cclk_fall;

  assign nco_sum     = {1'b0, nco_q} + {1'b0, NCO_INC};
  assign cclk_toggle = (mode_q == MODE_SUSPEND) ? nco_sum[NCO_W] : 1'b1;
  assign cclk_fall   = cclk_q && cclk_toggle;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cclk_q <= 1'b0;
      nco_q  <= {NCO_W{1'b0}};
    end
    else
    begin
      if (cclk_toggle)
        cclk_q <= !cclk_q;
      if (mode_q == MODE_SUSPEND)
        nco_q <= nco_sum[NCO_W-1:0];
      else
        nco_q <= {NCO_W{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // suspend entry and exit
  // ----------------------------------------------------------------
  logic               enter_req;
  logic               exit_req;

  assign enter_req = cclk_fall && enabled && iow_low && (code_eff == CODE_SUSP_IN);
  assign exit_req  = cclk_fall && (code_eff == CODE_SUSP_OUT);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_q <= MODE_RUN;
    else
    begin
      case (mode_q)
        MODE_RUN:
          if (enter_req)
            mode_q <= MODE_SUSPEND;
        MODE_SUSPEND:
          if (exit_req)
            mode_q <= MODE_RUN;
        default:
          mode_q <= MODE_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // refresh pulse in suspend
  // ----------------------------------------------------------------
  logic [REFRESH_CNT_W-1:0] ref_cnt_q;
  logic                     refresh_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_cnt_q <= {REFRESH_CNT_W{1'b0}};
      refresh_q <= 1'b0;
    end
    else if (mode_q == MODE_SUSPEND)
    begin
      if (ref_cnt_q == REFRESH_CNT_W'(REFRESH_PERIOD_CYC - 1))
        ref_cnt_q <= {REFRESH_CNT_W{1'b0}};
      else
        ref_cnt_q <= ref_cnt_q + 1'b1;
      refresh_q <= (ref_cnt_q < REFRESH_CNT_W'(REFRESH_PULSE_CYC));
    end
    else
    begin
      ref_cnt_q <= {REFRESH_CNT_W{1'b0}};
      refresh_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // code decoder
  // ----------------------------------------------------------------
  logic [SEL_N-1:0]   sel_d;
  logic [SEL_N-1:0]   sel_q;

  always_comb
  begin
    sel_d = {SEL_N{1'b0}};
    if (enabled)
    begin
      case (code_eff)
        CODE_ROM:      sel_d[SEL_ROM] = 1'b1;
        CODE_KBD:      sel_d[SEL_KBD] = 1'b1;
        CODE_COPROC:   sel_d[SEL_COPROC] = 1'b1;
        CODE_PWR0:     sel_d[SEL_PWR0] = 1'b1;
        CODE_PWR1:     sel_d[SEL_PWR1] = 1'b1;
        CODE_KBD_ACK:  sel_d[SEL_KBD_ACK] = 1'b1;
        CODE_RTC_ALE:  sel_d[SEL_RTC_ALE] = 1'b1;
        CODE_RTC_WR:   sel_d[SEL_RTC_WR] = iow_low;
        CODE_RTC_RD:   sel_d[SEL_RTC_RD] = ior_low;
        CODE_FLP_OUT:  sel_d[SEL_FLP_OUT] = 1'b1;
        CODE_FLP_CS:   sel_d[SEL_FLP_CS] = 1'b1;
        CODE_FLP_CTL:  sel_d[SEL_FLP_CTL] = 1'b1;
        CODE_FLP_IDE1:
        begin
          sel_d[SEL_FLP_CTL] = 1'b1;
          sel_d[SEL_IDE_LO]  = 1'b1;
          sel_d[SEL_IDE_CS1] = 1'b1;
        end
        CODE_IDE0:
        begin
          sel_d[SEL_IDE_LO]  = 1'b1;
          sel_d[SEL_IDE_CS0] = 1'b1;
          sel_d[SEL_IDE_HI]  = !sync_q[PIN_A0];
        end
        CODE_IDE1:
        begin
          sel_d[SEL_IDE_LO]  = 1'b1;
          sel_d[SEL_IDE_CS1] = 1'b1;
        end
        CODE_SER_A:    sel_d[SEL_SER_A] = 1'b1;
        CODE_PAR:      sel_d[SEL_PAR] = 1'b1;
        CODE_SER_B:    sel_d[SEL_SER_B] = 1'b1;
        CODE_PROG:     sel_d[SEL_PROG] = 1'b1;
        CODE_XMEM:     sel_d[SEL_XMEM] = 1'b1;
        default:       sel_d = {SEL_N{1'b0}};
      endcase
    end
    if (mode_q == MODE_SUSPEND)
    begin
      sel_d[SEL_SER_A] = 1'b1;
      sel_d[SEL_SER_B] = 1'b1;
      sel_d[SEL_PAR]   = 1'b1;
    end
  end

  // registered every cycle so a select drops one edge after its cause
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_q <= {SEL_N{1'b0}};
    else
      sel_q <= sel_d;
  end

  // ----------------------------------------------------------------
  // host data bus: status byte during an RTC read access only
  // ----------------------------------------------------------------
  logic               bus_oe_q;
  logic [DATA_W-1:0]  bus_out_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_oe_q  <= 1'b0;
      bus_out_q <= STATUS_IDLE;
    end
    else
    begin
      bus_oe_q  <= sel_d[SEL_RTC_RD];
      bus_out_q <= sel_d[SEL_RTC_RD] ? {STATUS_IDLE[DATA_W-1:1], mode_q == MODE_SUSPEND} : STATUS_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bios_rom_output_enable    = sel_q[SEL_ROM];
  assign kbd_ctrl_select           = sel_q[SEL_KBD];
  assign math_coproc_select        = sel_q[SEL_COPROC];
  assign power_unit0_write_strobe  = sel_q[SEL_PWR0];
  assign power_unit1_write_strobe  = sel_q[SEL_PWR1];
  assign kbd_proc_ack              = sel_q[SEL_KBD_ACK];
  assign rtc_addr_latch_enable     = sel_q[SEL_RTC_ALE];
  assign rtc_write_strobe          = sel_q[SEL_RTC_WR];
  assign rtc_read_strobe           = sel_q[SEL_RTC_RD];
  assign floppy_output_reg_select  = sel_q[SEL_FLP_OUT];
  assign floppy_chip_select        = sel_q[SEL_FLP_CS];
  assign floppy_control_reg_select = sel_q[SEL_FLP_CTL];
  assign ide_low_buffer_enable     = sel_q[SEL_IDE_LO];
  assign ide_high_buffer_enable    = sel_q[SEL_IDE_HI];
  assign ide_card_select_zero      = sel_q[SEL_IDE_CS0];
  assign ide_card_select_one       = sel_q[SEL_IDE_CS1];
  assign serial_a_select           = sel_q[SEL_SER_A];
  assign serial_b_select           = sel_q[SEL_SER_B];
  assign parallel_port_select      = sel_q[SEL_PAR];
  assign programmable_select       = sel_q[SEL_PROG];
  assign expanded_mem_select       = sel_q[SEL_XMEM];
  assign suspend_active            = (mode_q == MODE_SUSPEND);
  assign fast_clock_enable         = (mode_q == MODE_RUN);
  assign companion_clock_out       = cclk_q;
  assign suspend_refresh_pulse     = refresh_q;
  assign host_data_bus_out         = bus_out_q;
  assign host_data_bus_oe          = bus_oe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_disabled_quiet: assert property (!$past(enabled) && $past(mode_q == MODE_RUN)
    && mode_q == MODE_RUN |-> sel_q == '0) else $error("select active while decode disabled");
  a_rom_select: assert property (sel_q[SEL_ROM] == $past(enabled && code_eff == CODE_ROM))
    else $error("rom enable does not follow code 00");
  a_pwr_strobes: assert property (enabled && code_eff == CODE_PWR1 |=> sel_q[SEL_PWR1] && !sel_q[SEL_PWR0])
    else $error("power unit strobe wrong");
  a_rtc_write: assert property (sel_q[SEL_RTC_WR] |-> $past(enabled && iow_low && code_eff == CODE_RTC_WR))
    else $error("rtc write strobe without cause");
  a_ide_high: assert property (enabled && code_eff == CODE_IDE0
    |=> sel_q[SEL_IDE_HI] == !$past(sync_q[PIN_A0])) else $error("ide high enable not tied to a0");
  a_unused_code: assert property (enabled && (code_eff == 5'h12 || code_eff == 5'h13)
    && mode_q == MODE_RUN |=> sel_q == '0) else $error("unused code asserted a select");
  a_suspend_entry: assert property (mode_q == MODE_RUN && enter_req |=> suspend_active ##1 serial_a_select
    && serial_b_select && parallel_port_select) else $error("suspend entry failed");
  a_suspend_exit: assert property (mode_q == MODE_SUSPEND && exit_req |=> fast_clock_enable)
    else $error("suspend exit failed");
  a_refresh_width: assert property ($rose(refresh_q) |-> (refresh_q || mode_q == MODE_RUN)[*8]
    ##13 (!refresh_q || mode_q == MODE_RUN)) else $error("refresh pulse width wrong");
  a_refresh_idle: assert property (mode_q == MODE_RUN && $past(mode_q == MODE_RUN) |-> !refresh_q)
    else $error("refresh pulse outside suspend");
  a_fast_clock: assert property ($past(nrst) && mode_q == MODE_RUN && $past(mode_q == MODE_RUN)
    |-> cclk_q != $past(cclk_q)) else $error("companion clock stalled in run mode");
  a_bus_access: assert property (host_data_bus_oe |-> $past(ior_low && enabled))
    else $error("data bus driven outside an access");

endmodule // chip_select_code_decoder

`default_nettype wire

// ===== hdl/csd_pkg.sv
`default_nettype none

package csd_pkg;

  localparam int unsigned CODE_W = 5;
  localparam int unsigned DATA_W = 8;

  // select codes
  localparam logic [4:0] CODE_ROM       = 5'h00;
  localparam logic [4:0] CODE_KBD       = 5'h01;
  localparam logic [4:0] CODE_COPROC    = 5'h02;
  localparam logic [4:0] CODE_PWR0      = 5'h03;
  localparam logic [4:0] CODE_KBD_ACK   = 5'h04;
  localparam logic [4:0] CODE_RTC_ALE   = 5'h05;
  localparam logic [4:0] CODE_RTC_WR    = 5'h06;
  localparam logic [4:0] CODE_RTC_RD    = 5'h07;
  localparam logic [4:0] CODE_FLP_OUT   = 5'h08;
  localparam logic [4:0] CODE_FLP_CS    = 5'h09;
  localparam logic [4:0] CODE_FLP_CTL   = 5'h0A;
  localparam logic [4:0] CODE_FLP_IDE1  = 5'h0B;
  localparam logic [4:0] CODE_IDE0      = 5'h0C;
  localparam logic [4:0] CODE_IDE1      = 5'h0D;
  localparam logic [4:0] CODE_SER_A     = 5'h0E;
  localparam logic [4:0] CODE_PAR       = 5'h0F;
  localparam logic [4:0] CODE_SER_B     = 5'h10;
  localparam logic [4:0] CODE_PROG      = 5'h11;
  localparam logic [4:0] CODE_XMEM      = 5'h14;
  localparam logic [4:0] CODE_SUSP_IN   = 5'h15;
  localparam logic [4:0] CODE_SUSP_OUT  = 5'h16;
  localparam logic [4:0] CODE_PWR1      = 5'h17;

  // bit positions in the select vector
  localparam int unsigned SEL_ROM      = 0;
  localparam int unsigned SEL_KBD      = 1;
  localparam int unsigned SEL_COPROC   = 2;
  localparam int unsigned SEL_PWR0     = 3;
  localparam int unsigned SEL_PWR1     = 4;
  localparam int unsigned SEL_KBD_ACK  = 5;
  localparam int unsigned SEL_RTC_ALE  = 6;
  localparam int unsigned SEL_RTC_WR   = 7;
  localparam int unsigned SEL_RTC_RD   = 8;
  localparam int unsigned SEL_FLP_OUT  = 9;
  localparam int unsigned SEL_FLP_CS   = 10;
  localparam int unsigned SEL_FLP_CTL  = 11;
  localparam int unsigned SEL_IDE_LO   = 12;
  localparam int unsigned SEL_IDE_HI   = 13;
  localparam int unsigned SEL_IDE_CS0  = 14;
  localparam int unsigned SEL_IDE_CS1  = 15;
  localparam int unsigned SEL_SER_A    = 16;
  localparam int unsigned SEL_SER_B    = 17;
  localparam int unsigned SEL_PAR      = 18;
  localparam int unsigned SEL_PROG     = 19;
  localparam int unsigned SEL_XMEM     = 20;
  localparam int unsigned SEL_N        = 21;

  // synchroniser lanes
  localparam int unsigned PIN_CODE     = 0;
  localparam int unsigned PIN_EN_N     = 5;
  localparam int unsigned PIN_DACK     = 6;
  localparam int unsigned PIN_IOW_N    = 7;
  localparam int unsigned PIN_IOR_N    = 8;
  localparam int unsigned PIN_A0       = 9;
  localparam int unsigned PIN_ALE      = 10;
  localparam int unsigned PIN_N        = 11;

  // pins at rest: enable, write and read strobes high, so reset shows no request
  localparam logic [10:0] PIN_IDLE     = 11'h1A0;

  // timing
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned REFRESH_PULSE_NS   = 1000;
  localparam int unsigned REFRESH_PERIOD_PS  = 15260000;
  localparam int unsigned REFRESH_PULSE_CYC  = (REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_PERIOD_PS / (CLK_PERIOD_NS * 1000);
  localparam int unsigned REFRESH_CNT_W      = 9;

  // slow companion clock: phase accumulator, carry toggles the output
  localparam longint unsigned SLOW_CLK_HZ = 32768;
  localparam int unsigned     NCO_W       = 24;
  localparam longint unsigned NCO_INC_L   = (2 * SLOW_CLK_HZ * (64'd1 << NCO_W)) / (1000000000 / CLK_PERIOD_NS);
  localparam logic [23:0]     NCO_INC     = NCO_INC_L[23:0];

  localparam logic [7:0] STATUS_IDLE = 8'h00;

  typedef enum logic {MODE_RUN, MODE_SUSPEND} mode_t;

endpackage

`default_nettype wire

// ===== test/code_source.sv
`timescale 1ns/1ns
`default_nettype none

module code_source
(
  input  wire logic                        clk,
  output logic [csd_pkg::CODE_W-1:0]       select_code_lines,
  output logic                             decode_enable_n,
  output logic                             dma_ack_gate,
  output logic                             iow_n,
  output logic                             ior_n,
  output logic                             addr_a0,
  output logic                             bale
);
  import csd_pkg::*;

  initial
  begin
    select_code_lines = 5'h1F;
    decode_enable_n   = 1'b1;
    dma_ack_gate      = 1'b0;
    iow_n             = 1'b1;
    ior_n             = 1'b1;
    addr_a0           = 1'b0;
    bale              = 1'b0;
  end

  // all lines change together just after an edge and then stand
  task automatic present(input logic [4:0] c, input logic en_n, dk, wn, rn, a0, le);
    @(posedge clk);
    #1;
    select_code_lines = c;
    decode_enable_n   = en_n;
    dma_ack_gate      = dk;
    iow_n             = wn;
    ior_n             = rn;
    addr_a0           = a0;
    bale              = le;
  endtask
endmodule // code_source

`default_nettype wire

// ===== test/chip_select_code_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none

module chip_select_code_decoder_test;
  import csd_pkg::*;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        bale_in_use = 1'b0;
  logic [4:0]  code;
  logic        en_n, dack, wn, rn, a0, ale;
  logic [20:0] sel;
  logic [7:0]  dbo;
  logic        dboe, fce, susp, cko, rfp;
  logic        s_a, s_b, par, rom, kbd, cop, p0, p1, ack, ale_o, rw, rr, fo, fc, fl, il, ih, c0, c1, pg, xm;
  int          num_errors = 0;
  int          cmp_count = 0;

  initial
  begin
    forever #25 clk = ~clk;
  end

  code_source u_src (.clk(clk), .select_code_lines(code), .decode_enable_n(en_n), .dma_ack_gate(dack),
    .iow_n(wn), .ior_n(rn), .addr_a0(a0), .bale(ale));

  chip_select_code_decoder u_dut (.clk(clk), .nrst(nrst), .select_code_lines(code), .decode_enable_n(en_n),
    .dma_ack_gate(dack), .iow_n(wn), .ior_n(rn), .addr_a0(a0), .bale(ale), .bale_in_use(bale_in_use),
    .bios_rom_output_enable(rom), .kbd_ctrl_select(kbd), .math_coproc_select(cop),
    .power_unit0_write_strobe(p0), .power_unit1_write_strobe(p1), .kbd_proc_ack(ack),
    .rtc_addr_latch_enable(ale_o), .rtc_write_strobe(rw), .rtc_read_strobe(rr),
    .floppy_output_reg_select(fo), .floppy_chip_select(fc), .floppy_control_reg_select(fl),
    .ide_low_buffer_enable(il), .ide_high_buffer_enable(ih), .ide_card_select_zero(c0),
    .ide_card_select_one(c1), .serial_a_select(s_a), .serial_b_select(s_b), .parallel_port_select(par),
    .programmable_select(pg), .expanded_mem_select(xm), .fast_clock_enable(fce), .suspend_active(susp),
    .companion_clock_out(cko), .suspend_refresh_pulse(rfp), .host_data_bus_out(dbo),
    .host_data_bus_oe(dboe));

  assign sel = {xm, pg, par, s_b, s_a, c1, c0, ih, il, fl, fc, fo, rr, rw, ale_o, ack, p1, p0, cop, kbd, rom};

  function automatic logic [20:0] bit_of(input int unsigned i);
    return 21'h1 << i;
  endfunction

  // expected selects from the code table, decoding enabled
  function automatic logic [20:0] exp_sel(input logic [4:0] c, input logic w, r, a);
    case (c)
      5'h00: return bit_of(SEL_ROM);
      5'h01: return bit_of(SEL_KBD);
      5'h02: return bit_of(SEL_COPROC);
      5'h03: return bit_of(SEL_PWR0);
      5'h04: return bit_of(SEL_KBD_ACK);
      5'h05: return bit_of(SEL_RTC_ALE);
      5'h06: return w ? 21'h0 : bit_of(SEL_RTC_WR);
      5'h07: return r ? 21'h0 : bit_of(SEL_RTC_RD);
      5'h08: return bit_of(SEL_FLP_OUT);
      5'h09: return bit_of(SEL_FLP_CS);
      5'h0A: return bit_of(SEL_FLP_CTL);
      5'h0B: return bit_of(SEL_FLP_CTL) | bit_of(SEL_IDE_LO) | bit_of(SEL_IDE_CS1);
      5'h0C: return bit_of(SEL_IDE_LO) | bit_of(SEL_IDE_CS0) | (a ? 21'h0 : bit_of(SEL_IDE_HI));
      5'h0D: return bit_of(SEL_IDE_LO) | bit_of(SEL_IDE_CS1);
      5'h0E: return bit_of(SEL_SER_A);
      5'h0F: return bit_of(SEL_PAR);
      5'h10: return bit_of(SEL_SER_B);
      5'h11: return bit_of(SEL_PROG);
      5'h14: return bit_of(SEL_XMEM);
      5'h17: return bit_of(SEL_PWR1);
      default: return 21'h0;
    endcase
  endfunction

  task automatic cmp(input logic [20:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sel(input logic [20:0] exp);
    cmp(sel, exp);
  endtask

  task automatic chk_val(input logic [7:0] got, exp);
    cmp({13'h0, got}, {13'h0, exp});
  endtask

  task automatic chk_cnt(input int got, exp);
    cmp(got[20:0], exp[20:0]);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic do_reset(input logic use_ale);
    nrst = 1'b0;
    bale_in_use = use_ale;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
  endtask

  task automatic t_table;
    logic [4:0] c;
    logic       w, r, a;
    for (int k = 0; k < 128; k++)
    begin
      c = k[4:0];
      a = k[5];
      w = !(k[6] && c == 5'h06);
      r = !(k[6] && c == 5'h07);
      u_src.present(c, 1'b0, 1'b0, w, r, a, 1'b0);
      settle(4);
      chk_sel(exp_sel(c, w, r, a));
      chk_val({7'h0, dboe}, {7'h0, c == 5'h07 && !r});
      chk_val(dbo, 8'h00);
    end
    chk_val({7'h0, susp}, 8'h00);
  endtask

  task automatic t_gate;
    u_src.present(5'h02, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_sel(21'h0);
    u_src.present(5'h02, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_sel(21'h0);
    u_src.present(5'h02, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_sel(exp_sel(5'h02, 1'b1, 1'b1, 1'b0));
    u_src.present(5'h13, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_sel(21'h0);
  endtask

  task automatic t_latch;
    do_reset(1'b1);
    u_src.present(5'h09, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    settle(4);
    u_src.present(5'h09, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    u_src.present(5'h1F, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_sel(exp_sel(5'h09, 1'b1, 1'b1, 1'b0));
    do_reset(1'b0);
  endtask

  task automatic t_suspend;
    logic v;
    int   n;
    settle(1);
    v = cko;
    settle(1);
    chk_val({7'h0, cko}, {7'h0, ~v});
    u_src.present(5'h15, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    settle(6);
    u_src.present(5'h1F, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_val({6'h0, susp, fce}, 8'h02);
    chk_sel(bit_of(SEL_SER_A) | bit_of(SEL_SER_B) | bit_of(SEL_PAR));
    u_src.present(5'h07, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    settle(4);
    chk_sel(bit_of(SEL_SER_A) | bit_of(SEL_SER_B) | bit_of(SEL_PAR) | bit_of(SEL_RTC_RD));
    chk_val({7'h0, dboe}, 8'h01);
    chk_val(dbo, 8'h01);
    u_src.present(5'h1F, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (rfp === 1'b1 && n < 400)
    begin
      settle(1);
      n++;
    end
    n = 0;
    while (rfp !== 1'b1 && n < 400)
    begin
      settle(1);
      n++;
    end
    n = 0;
    while (rfp === 1'b1 && n < 400)
    begin
      settle(1);
      n++;
    end
    chk_cnt(n, 20);
    while (rfp !== 1'b1 && n < 400)
    begin
      settle(1);
      n++;
    end
    chk_cnt(n, 305);
    v = cko;
    n = 0;
    while (cko === v && n < 700)
    begin
      settle(1);
      n++;
    end
    v = cko;
    n = 0;
    while (cko === v && n < 700)
    begin
      settle(1);
      n++;
    end
    chk_val({7'h0, n == 305 || n == 306}, 8'h01);
    u_src.present(5'h16, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (susp !== 1'b0 && n < 1500)
    begin
      settle(1);
      n++;
    end
    u_src.present(5'h1F, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk_val({6'h0, susp, fce}, 8'h01);
    chk_sel(21'h0);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #(20000 * 50);
    num_errors++;
    end_sim();
  end

  initial
  begin
    do_reset(1'b0);
    t_table();
    t_gate();
    t_latch();
    t_suspend();
    end_sim();
  end
endmodule // chip_select_code_decoder_test

`default_nettype wire
